// File: logic/foc_consts.svh
// constants of the offset compensation block
`ifndef FOC_CONSTS_SVH
`define FOC_CONSTS_SVH

// =====================================================================
// register map
`define FOC_ADDR_CFG        8'h18
`define FOC_ADDR_STAT       8'h1c
`define FOC_ADDR_PWR        8'h20

// =====================================================================
// reset values
`define FOC_CFG_RESET       6'h36
`define FOC_PWR_RESET       2'h1
`define FOC_GAIN_RESET      4'h6
`define FOC_LIM_RESET       2'h2

// =====================================================================
// configuration fields
`define FOC_GATE_BIT        5
`define FOC_PRE_MSB         4
`define FOC_PRE_LSB         3
`define FOC_POST_BIT        2
`define FOC_LIM_MSB         1
`define FOC_LIM_LSB         0
`define FOC_LIM_OFF         2'h0

// =====================================================================
// loop gain codes, in units of half the base gain
`define FOC_GAIN_HALF       4'h1
`define FOC_GAIN_K          4'h2

// =====================================================================
// power-on timeout
`define FOC_RIPPLE_CYC      64
`define FOC_EXP_SEL0        9'h001
`define FOC_EXP_SEL1        9'h010
`define FOC_EXP_SEL2        9'h040
`define FOC_EXP_SEL3        9'h100

// =====================================================================
// bus encodings
`define FOC_HTRANS_ACT_BIT  1
`define FOC_HSIZE_WORD      3'h2
`define FOC_HRESP_OKAY      1'h0

`endif

// File: logic/foc_pkg.sv
// types of the offset compensation block
package foc_pkg;

  typedef logic [3:0] foc_gain_t;

  typedef enum logic [1:0] {
    FOC_IDLE = 2'h0,
    FOC_PRE  = 2'h1,
    FOC_POST = 2'h3
  } foc_rx_state_e;

  typedef struct packed {
    logic [5:0]    cfg;
    logic [1:0]    pwr_sel;
    logic          xosc_meta;
    logic          xosc_sync;
    foc_rx_state_e st;
    logic          carrier_seen;
    logic          freeze;
    foc_gain_t     gain;
    logic [1:0]    limit;
    logic          comp_en;
  } foc_top_s;

  typedef struct packed {
    logic        pend_wr;
    logic        pend_rd;
    logic        in_range;
    logic [7:0]  addr;
    logic        hready;
    logic [31:0] hrdata;
  } foc_ahb_s;

  typedef struct packed {
    logic [15:0] ripple;
    logic [8:0]  expired;
    logic        stable;
    logic        ready_low;
  } foc_tmr_s;

endpackage

// File: logic/foc_reg_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ns
interface foc_reg_if;
  logic        wr_en;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output wr_en, output addr, output wdata, input rdata);
  modport regs  (input wr_en, input addr, input wdata, output rdata);
endinterface

// File: logic/foc_ahb_slave.sv
// ahb-lite slave front end of the register file
`timescale 1ns/1ns
`include "foc_consts.svh"
module foc_ahb_slave (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // ahb-lite
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  // register side
  foc_reg_if.slave         bus
);
  import foc_pkg::*;

  localparam foc_ahb_s AHB_RST = '{pend_wr: 1'h0, pend_rd: 1'h0, in_range: 1'h0,
                                   addr: 8'h00, hready: 1'h1, hrdata: 32'h0};

  foc_ahb_s s_q;
  foc_ahb_s s_d;

  // =====================================================================
  // transfer tracking
  always_comb begin
    s_d = s_q;
    s_d.pend_wr = 1'h0;
    if (s_q.pend_rd) begin
      s_d.pend_rd = 1'h0;
      s_d.hready  = 1'h1;
      s_d.hrdata  = s_q.in_range ? bus.rdata : 32'h0;
    end
    if (hsel_in && hready_in && htrans_in[`FOC_HTRANS_ACT_BIT]) begin
      s_d.addr     = haddr_in[7:0];
      s_d.in_range = (haddr_in[31:8] == 24'h0) && (haddr_in[1:0] == 2'h0) && (hsize_in == `FOC_HSIZE_WORD);
      s_d.pend_wr  = hwrite_in;
      s_d.pend_rd  = !hwrite_in;
      s_d.hready   = hwrite_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_q <= AHB_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.wr_en     = s_q.pend_wr & s_q.in_range;
  assign bus.addr      = s_q.addr;
  assign bus.wdata     = hwdata_in;
  assign hrdata_out    = s_q.hrdata;
  assign hreadyout_out = s_q.hready;
endmodule

// File: logic/foc_po_timer.sv
// power-on timeout for crystal stable and chip ready
`timescale 1ns/1ns
`include "foc_consts.svh"
module foc_po_timer #(
  parameter int RIPPLE_CYCLES = `FOC_RIPPLE_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // control
  input  wire logic       osc_ok_in,
  input  wire logic [1:0] sel_in,
  // indications
  output logic            crystal_stable_flag_out,
  output logic            chip_ready_low_out
);
  import foc_pkg::*;

  localparam logic [15:0] RLAST = 16'(RIPPLE_CYCLES - 1);
  localparam foc_tmr_s TMR_RST = '{ripple: 16'h0, expired: 9'h0, stable: 1'h0, ready_low: 1'h1};

  foc_tmr_s   s_q;
  foc_tmr_s   s_d;
  logic [8:0] target;
  logic [8:0] exp_next;

  // =====================================================================
  // ripple expirations
  always_comb begin
    s_d = s_q;
    unique case (sel_in)
      2'h0: target = `FOC_EXP_SEL0;
      2'h1: target = `FOC_EXP_SEL1;
      2'h2: target = `FOC_EXP_SEL2;
      2'h3: target = `FOC_EXP_SEL3;
    endcase
    exp_next = s_q.expired + 9'h001;
    if (!osc_ok_in) begin
      s_d = TMR_RST;
    end else if (!s_q.stable) begin
      if (s_q.ripple == RLAST) begin
        s_d.ripple  = 16'h0;
        s_d.expired = exp_next;
        if (exp_next >= target) begin
          s_d.stable    = 1'h1;
          s_d.ready_low = 1'h0;
        end
      end else begin
        s_d.ripple = s_q.ripple + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_q <= TMR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign crystal_stable_flag_out = s_q.stable;
  assign chip_ready_low_out      = s_q.ready_low;
endmodule

// File: logic/foc_comp_top.sv
// frequency offset compensation control with register file
//
// Overview of operation
// - with the gate bit set, both the offset loop and clock recovery stay frozen until carrier sense rises.
// - before sync, loop gain follows bits 4:3 as K, 2K, 3K, 4K, reset giving 3K.
// - after sync, bit 2 set selects K/2 and clear keeps the pre-sync gain.
// - bits 1:0 set saturation at off, bandwidth/8, /4, /2, reset giving /4.
// - crystal stable and chip ready assert in the same cycle after the power-on timeout.
`timescale 1ns/1ns
`include "foc_consts.svh"
module foc_comp_top #(
  parameter int RIPPLE_CYCLES = `FOC_RIPPLE_CYC
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  // ahb-lite
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // demodulator events
  input  wire logic              carrier_sense_in,
  input  wire logic              sync_detect_in,
  input  wire logic              rx_start_in,
  input  wire logic              rx_end_in,
  // crystal oscillator pin
  input  wire logic              xosc_running_in,
  // loop control
  output logic                   offset_loop_freeze_out,
  output logic                   clock_recovery_freeze_out,
  output foc_pkg::foc_gain_t     offset_gain_out,
  output logic      [1:0]        offset_saturation_out,
  output logic                   offset_comp_enable_out,
  // power-on indications
  output logic                   crystal_stable_flag_out,
  output logic                   chip_ready_low_out
);
  import foc_pkg::*;

  // =====================================================================
  // elaboration checks
  generate
    if (RIPPLE_CYCLES < 1 || RIPPLE_CYCLES > 65535) begin : g_bad_ripple
      $error("ripple period out of range");
    end
  endgenerate

  localparam foc_top_s TOP_RST = '{cfg: `FOC_CFG_RESET, pwr_sel: `FOC_PWR_RESET, xosc_meta: 1'h0,
                                   xosc_sync: 1'h0, st: FOC_IDLE, carrier_seen: 1'h0, freeze: 1'h1,
                                   gain: `FOC_GAIN_RESET, limit: `FOC_LIM_RESET, comp_en: 1'h1};

  foc_top_s  s_q;
  foc_top_s  s_d;
  foc_gain_t pre_gain;
  foc_gain_t post_gain;
  logic [11:0] status;

  foc_reg_if bus ();

  function automatic foc_gain_t pre_gain_f(input logic [1:0] code);
    return {1'h0, code, 1'h0} + `FOC_GAIN_K;
  endfunction

  // =====================================================================
  // bus slave
  foc_ahb_slave u_ahb (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .hrdata_out    (hrdata_out),
    .hreadyout_out (hreadyout_out),
    .bus           (bus.slave)
  );

  assign hresp_out = `FOC_HRESP_OKAY;

  // =====================================================================
  // power-on timeout
  foc_po_timer #(
    .RIPPLE_CYCLES (RIPPLE_CYCLES)
  ) u_po (
    .ref_clk_in              (ref_clk_in),
    .reset_in                (reset_in),
    .osc_ok_in               (s_q.xosc_sync),
    .sel_in                  (s_q.pwr_sel),
    .crystal_stable_flag_out (crystal_stable_flag_out),
    .chip_ready_low_out      (chip_ready_low_out)
  );

  // =====================================================================
  // register read
  assign status = {s_q.limit, s_q.gain, s_q.freeze, s_q.st, s_q.carrier_seen,
                   chip_ready_low_out, crystal_stable_flag_out};

  always_comb begin
    unique case (bus.addr)
      `FOC_ADDR_CFG:  bus.rdata = 32'(s_q.cfg);
      `FOC_ADDR_STAT: bus.rdata = 32'(status);
      `FOC_ADDR_PWR:  bus.rdata = 32'(s_q.pwr_sel);
      default:        bus.rdata = 32'h0;
    endcase
  end

  // =====================================================================
  // control state
  always_comb begin
    s_d = s_q;
    s_d.xosc_meta = xosc_running_in;
    s_d.xosc_sync = s_q.xosc_meta;
    if (bus.wr_en && bus.addr == `FOC_ADDR_CFG) begin
      s_d.cfg = bus.wdata[5:0];
    end
    if (bus.wr_en && bus.addr == `FOC_ADDR_PWR) begin
      s_d.pwr_sel = bus.wdata[1:0];
    end
    // reception tracking, new reception wins over sync
    if (rx_start_in) begin
      s_d.st           = FOC_PRE;
      s_d.carrier_seen = 1'h0;
    end else if (rx_end_in) begin
      s_d.st = FOC_IDLE;
    end else if (sync_detect_in && s_q.st == FOC_PRE) begin
      s_d.st = FOC_POST;
    end
    if (carrier_sense_in) begin
      s_d.carrier_seen = 1'h1;
    end
    s_d.freeze  = s_d.cfg[`FOC_GATE_BIT] & ~s_d.carrier_seen;
    pre_gain    = pre_gain_f(s_d.cfg[`FOC_PRE_MSB:`FOC_PRE_LSB]);
    post_gain   = s_d.cfg[`FOC_POST_BIT] ? `FOC_GAIN_HALF : pre_gain;
    s_d.gain    = (s_d.st == FOC_POST) ? post_gain : pre_gain;
    s_d.limit   = s_d.cfg[`FOC_LIM_MSB:`FOC_LIM_LSB];
    s_d.comp_en = s_d.limit != `FOC_LIM_OFF;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign offset_loop_freeze_out    = s_q.freeze;
  assign clock_recovery_freeze_out = s_q.freeze;
  assign offset_gain_out           = s_q.gain;
  assign offset_saturation_out     = s_q.limit;
  assign offset_comp_enable_out    = s_q.comp_en;

  // =====================================================================
  // assertions
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  logic past_valid_q;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      past_valid_q <= 1'h0;
    end else begin
      past_valid_q <= 1'h1;
    end
  end

  AST_FREEZE_HOLD: assert property (
    (s_q.cfg[`FOC_GATE_BIT] && !carrier_sense_in && (rx_start_in || !s_q.carrier_seen) &&
     !bus.wr_en) |=> (offset_loop_freeze_out && clock_recovery_freeze_out))
    else $error("loops not frozen while waiting for carrier");

  AST_FREEZE_RELEASE: assert property (
    carrier_sense_in |=> (!offset_loop_freeze_out && !clock_recovery_freeze_out) [*1] ##1
      (!offset_loop_freeze_out || $past(rx_start_in) || $past(bus.wr_en)))
    else $error("loops still frozen after carrier sense");

  AST_PRE_GAIN: assert property (
    (past_valid_q && s_q.st != FOC_POST) |->
      offset_gain_out == pre_gain_f(s_q.cfg[`FOC_PRE_MSB:`FOC_PRE_LSB]))
    else $error("pre-sync gain does not follow its field");

  AST_POST_GAIN: assert property (
    (past_valid_q && s_q.st == FOC_POST) |->
      offset_gain_out == (s_q.cfg[`FOC_POST_BIT] ? `FOC_GAIN_HALF :
                          pre_gain_f(s_q.cfg[`FOC_PRE_MSB:`FOC_PRE_LSB])))
    else $error("post-sync gain wrong");

  AST_LIMIT: assert property (
    past_valid_q |-> (offset_saturation_out == s_q.cfg[`FOC_LIM_MSB:`FOC_LIM_LSB] &&
                      offset_comp_enable_out == (offset_saturation_out != `FOC_LIM_OFF)))
    else $error("saturation select or enable wrong");

  AST_READY_TOGETHER: assert property (
    crystal_stable_flag_out == !chip_ready_low_out)
    else $error("crystal stable and chip ready apart");

  AST_READY_ONCE: assert property (
    $rose(crystal_stable_flag_out) |-> $fell(chip_ready_low_out) && $past(s_q.xosc_sync, 1))
    else $error("ready rose without stable oscillator");

  AST_RX_RESTART: assert property (
    rx_start_in |=> (s_q.st == FOC_PRE && (!s_q.carrier_seen || $past(carrier_sense_in))))
    else $error("new reception did not return to pre-sync");

  AST_SYNC_SWITCH: assert property (
    (sync_detect_in && !rx_start_in && !rx_end_in && s_q.st == FOC_PRE) |=>
      s_q.st == FOC_POST ##1 (s_q.st == FOC_POST || $past(rx_start_in) || $past(rx_end_in)))
    else $error("sync did not switch to post-sync gain");

  AST_READ_WAIT: assert property (
    (hsel_in && hready_in && htrans_in[`FOC_HTRANS_ACT_BIT] && !hwrite_in) |=>
      !hreadyout_out ##1 hreadyout_out)
    else $error("read did not take exactly one wait state");

  // =====================================================================
  // further checks

  AST_GATE_OFF_RUN: assert property (
    (!s_q.cfg[`FOC_GATE_BIT] && !bus.wr_en) |=> (!offset_loop_freeze_out && !clock_recovery_freeze_out))
    else $error("loops frozen with gating off");

  AST_CARRIER_KEPT: assert property (
    (s_q.carrier_seen && !rx_start_in && !bus.wr_en) |=> !offset_loop_freeze_out)
    else $error("loops frozen again without a new reception");

  AST_CS_CLEARED: assert property (
    (rx_start_in && !carrier_sense_in) |=> !s_q.carrier_seen)
    else $error("carrier seen survived a new reception");

  AST_SYNC_IGNORED: assert property (
    (sync_detect_in && s_q.st == FOC_IDLE && !rx_start_in) |=> s_q.st == FOC_IDLE)
    else $error("sync accepted outside a reception");

  AST_RX_END_IDLE: assert property (
    (rx_end_in && !rx_start_in) |=> s_q.st == FOC_IDLE)
    else $error("reception end ignored");

  AST_PRE_HOLD: assert property (
    (s_q.st == FOC_PRE && !rx_start_in && !rx_end_in && !sync_detect_in) |=> s_q.st == FOC_PRE)
    else $error("pre-sync state left without cause");

  AST_POST_HOLD: assert property (
    (s_q.st == FOC_POST && !rx_start_in && !rx_end_in) |=> s_q.st == FOC_POST)
    else $error("post-sync state left without cause");

  AST_HALF_ONLY_POST: assert property (
    (offset_gain_out == `FOC_GAIN_HALF) |-> s_q.st == FOC_POST)
    else $error("half gain outside post-sync");

  AST_GAIN_STABLE: assert property (
    (!bus.wr_en && !rx_start_in && !rx_end_in && !sync_detect_in) |=> $stable(offset_gain_out))
    else $error("gain moved without cause");

  AST_SAT_STABLE: assert property (
    !bus.wr_en |=> $stable(offset_saturation_out))
    else $error("saturation moved without a write");

  AST_READY_HOLD: assert property (
    (crystal_stable_flag_out && s_q.xosc_sync) |=> (crystal_stable_flag_out && !chip_ready_low_out))
    else $error("ready dropped with oscillator running");

  AST_OSC_LOSS: assert property (
    !s_q.xosc_sync |=> (!crystal_stable_flag_out && chip_ready_low_out))
    else $error("ready kept without oscillator");

  AST_WRITE_NO_WAIT: assert property (
    (hsel_in && hready_in && htrans_in[`FOC_HTRANS_ACT_BIT] && hwrite_in) |=> hreadyout_out)
    else $error("write took a wait state");

  AST_UNALIGNED_READ: assert property (
    (hsel_in && hready_in && htrans_in[`FOC_HTRANS_ACT_BIT] && !hwrite_in && haddr_in[1:0] != 2'h0) |=>
      ##1 hrdata_out == 32'h0)
    else $error("unaligned read returned data");

  AST_CFG_WRITE: assert property (
    (bus.wr_en && bus.addr == `FOC_ADDR_CFG) |=> s_q.cfg == $past(bus.wdata[5:0]))
    else $error("configuration write lost");

  COV_OSC_LOSS: cover property (
    $fell(crystal_stable_flag_out));

  COV_POST_HALF: cover property (
    s_q.st == FOC_PRE ##1 s_q.st == FOC_POST && offset_gain_out == `FOC_GAIN_HALF);

  COV_CARRIER_UNFREEZE: cover property (
    offset_loop_freeze_out ##1 !offset_loop_freeze_out);

  COV_READY: cover property (
    $fell(chip_ready_low_out));

  COV_CFG_WRITE: cover property (
    bus.wr_en && bus.addr == `FOC_ADDR_CFG ##1 offset_saturation_out == `FOC_LIM_OFF);
endmodule

// File: verification/freq_offset_comp_config_test.sv
// self-checking bench of the offset compensation block
`timescale 1ns/1ns
`include "foc_consts.svh"
module freq_offset_comp_config_test;
  import foc_pkg::*;

  // ===================================================================
  // stimulus and observed signals
  logic        ref_clk_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic [2:0]  hsize      = 3'h2;
  logic        carrier    = 1'b0;
  logic        sync_det   = 1'b0;
  logic        rx_start   = 1'b0;
  logic        rx_end     = 1'b0;
  logic        xosc       = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        loop_frz;
  logic        clk_frz;
  foc_gain_t   gain;
  logic [1:0]  sat;
  logic        comp_en;
  logic        flag;
  logic        ready_low;
  logic [31:0] q;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          n;

  foc_comp_top #(.RIPPLE_CYCLES(2)) uut (
    .ref_clk_in                (ref_clk_in),
    .reset_in                  (reset_in),
    .hsel_in                   (hsel),
    .haddr_in                  (haddr),
    .htrans_in                 (htrans),
    .hwrite_in                 (hwrite),
    .hsize_in                  (hsize),
    .hwdata_in                 (hwdata),
    .hready_in                 (hready),
    .hrdata_out                (hrdata),
    .hreadyout_out             (hready),
    .hresp_out                 (hresp),
    .carrier_sense_in          (carrier),
    .sync_detect_in            (sync_det),
    .rx_start_in               (rx_start),
    .rx_end_in                 (rx_end),
    .xosc_running_in           (xosc),
    .offset_loop_freeze_out    (loop_frz),
    .clock_recovery_freeze_out (clk_frz),
    .offset_gain_out           (gain),
    .offset_saturation_out     (sat),
    .offset_comp_enable_out    (comp_en),
    .crystal_stable_flag_out   (flag),
    .chip_ready_low_out        (ready_low)
  );

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ===================================================================
  // bus, event and compare tasks
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    int   k;
    logic r;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    k = 0;
    do begin
      @(negedge ref_clk_in);
      r = hready;
      @(posedge ref_clk_in);
      k++;
    end while (r !== 1'b1 && k < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin
      @(negedge ref_clk_in);
      r  = hready;
      rd = hrdata;
      @(posedge ref_clk_in);
      k++;
    end while (r !== 1'b1 && k < 50);
    if (r !== 1'b1 || hresp !== `FOC_HRESP_OKAY) begin
      mismatches++;
      $display("MISMATCH %0t bus answer missing or not okay", $time);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] got;
    bus(1'b0, a, 32'h0, got);
    tests_run++;
    if (got !== e) begin
      mismatches++;
      $display("MISMATCH %0t read %h got %h expected %h", $time, a, got, e);
    end
  endtask

  // pulses {rx_start, sync, carrier, rx_end} for one cycle
  task automatic ev(input logic [3:0] m);
    {rx_start, sync_det, carrier, rx_end} <= m;
    @(posedge ref_clk_in);
    {rx_start, sync_det, carrier, rx_end} <= 4'h0;
    @(posedge ref_clk_in);
  endtask

  // expected {loop freeze, recovery freeze, gain, saturation, enable}
  task automatic chk_out(input logic [8:0] e);
    @(negedge ref_clk_in);
    tests_run++;
    if ({loop_frz, clk_frz, gain, sat, comp_en} !== e) begin
      mismatches++;
      $display("MISMATCH %0t loop outputs %h expected %h", $time, {loop_frz, clk_frz, gain, sat, comp_en}, e);
    end
    @(posedge ref_clk_in);
  endtask

  // waits for the crystal flag to reach v, checking both indications each cycle
  task automatic wait_flag(input logic v, output int cyc);
    logic f;
    cyc = 0;
    do begin
      @(negedge ref_clk_in);
      tests_run++;
      if (ready_low !== ~flag) begin
        mismatches++;
        $display("MISMATCH %0t ready and stable disagree", $time);
      end
      f = flag;
      @(posedge ref_clk_in);
      cyc++;
    end while (f !== v && cyc < 200);
  endtask

  task automatic chk_range(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH %0t delay %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end

  // ===================================================================
  // test sequence
  initial begin
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    chk_out(9'b1_1_0110_10_1);
    chk_rd(32'h18, 32'h36);
    chk_rd(32'h20, 32'h1);
    chk_rd(32'h24, 32'h0);
    wr(32'h24, 32'hffffffff);
    chk_rd(32'h18, 32'h36);
    wr(32'h18, 32'hffffffff);
    chk_rd(32'h18, 32'h3f);
    wr(32'h118, 32'h0);
    chk_rd(32'h19, 32'h0);
    chk_rd(32'h18, 32'h3f);
    // power-on: default timeout of 16 expiries
    xosc <= 1'b1;
    wait_flag(1'b1, n);
    chk_range(n, 32, 38);
    xosc <= 1'b0;
    wait_flag(1'b0, n);
    chk_range(n, 1, 6);
    wr(32'h20, 32'h0);
    chk_rd(32'h20, 32'h0);
    xosc <= 1'b1;
    wait_flag(1'b1, n);
    chk_range(n, 2, 8);
    // every gain and saturation code, with and without the post-sync drop
    for (int c = 0; c < 4; c++) begin
      wr(32'h18, {26'h0, 1'b0, 2'(c), 1'b1, 2'(c)});
      chk_rd(32'h18, {26'h0, 1'b0, 2'(c), 1'b1, 2'(c)});
      ev(4'b1000);
      chk_out({2'b00, 4'(2 * (c + 1)), 2'(c), c != 0});
      ev(4'b0100);
      chk_out({2'b00, 4'h1, 2'(c), c != 0});
      wr(32'h18, {26'h0, 1'b0, 2'(c), 1'b0, 2'(c)});
      ev(4'b1000);
      ev(4'b0100);
      chk_out({2'b00, 4'(2 * (c + 1)), 2'(c), c != 0});
      ev(4'b0001);
    end
    // gating until carrier sense
    wr(32'h18, 32'h36);
    ev(4'b1000);
    chk_out(9'b1_1_0110_10_1);
    ev(4'b0100);
    chk_out(9'b1_1_0001_10_1);
    ev(4'b0010);
    chk_out(9'b0_0_0001_10_1);
    ev(4'b1000);
    chk_out(9'b1_1_0110_10_1);
    // on-off keying setup: compensation off
    wr(32'h18, 32'h30);
    ev(4'b1000);
    chk_out(9'b1_1_0110_00_0);
    chk_rd(32'h1c, 32'h1a9);
    close_out();
  end
endmodule
